// File: gatekeeper_map.vh
// Register offsets, field positions, reset values and error codes of the command gatekeeper
`ifndef GATEKEEPER_MAP_VH
`define GATEKEEPER_MAP_VH
`define OFS_CMD        4'h0
`define OFS_OPERAND    4'h1
`define OFS_RESULT     4'h2
`define OFS_AXSTAT_X   4'h3
`define OFS_AXSTAT_Y   4'h4
`define OFS_STEP_X     4'h5
`define OFS_STEP_Y     4'h6
`define OFS_POS_X      4'h7
`define OFS_POS_Y      4'h8
`define OFS_ENC_X      4'h9
`define OFS_ENC_Y      4'hA
`define OFS_AXCFG      4'hB
`define OFS_IRQ_STAT   4'hC
`define OFS_IRQ_MASK   4'hD
`define CMD_REQ_BIT    0
`define CMD_AXIS_BIT   1
`define CMD_CANCEL_BIT 2
`define CMD_CODE_LSB   4
`define CMD_CODE_MSB   6
`define CODE_PTV       3'h1
`define CODE_STEP      3'h2
`define CODE_RSTEP     3'h3
`define CODE_PPRE      3'h4
`define CODE_EPRE      3'h5
`define CODE_ECLR      3'h6
`define ST_OPER_BIT    0
`define ST_POSCTL_BIT  1
`define ST_ERR_BIT     2
`define ST_ORIGIN_BIT  3
`define ST_INHIB_BIT   4
`define CFG_REPEAT_X   0
`define CFG_REPEAT_Y   1
`define CFG_UNIT_LSB   4
`define STEP_RESET     8'h01
`define STEP_MAX       8'h96
`define ERR_NONE       16'h0000
`define ERR_PTV_RUN    16'd311
`define ERR_PTV_POS    16'd317
`define ERR_STEP_RUN   16'd441
`define ERR_STEP_RANGE 16'd442
`define ERR_RSTEP_MODE 16'd443
`define ERR_PPRE_RUN   16'd451
`define ERR_AXIS_FAULT 16'd1
`define ERR_BAD_CMD    16'd2
`define IRQ_DONE_BIT   0
`define IRQ_FAIL_BIT   1
`endif

// File: axis_command_gatekeeper.v
// Per-axis command gatekeeper with an Avalon-MM register slave
// Summary of operation
// - Reject pos-to-speed on running axis: 311
// - Pos-to-speed only under position control, else 317
// - Drive per-axis position-control flag
// - Drive per-axis operating flag
// - Reject step change on running axis: 441
// - Load requested step into step pointer
// - Steps 1 to 150 per axis
// - Repeat step change only in Repeat method
// - Reject position preset on running axis: 451
// - Preset sets origin-decided when not established
// - Preset value unit from basic unit parameter
// - Encoder preset overwrites encoder count
// - Error flag blocks motion commands on axis
// - Done 1 on success, held; 0 on failure
// - Failure reports numeric error code
// - Error clear, optional inhibition cancel
`timescale 1ns/1ns
`include "gatekeeper_map.vh"
module axis_command_gatekeeper (
  input wire ref_clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [1:0] axis_running,
  input wire [1:0] axis_pos_ctl,
  input wire [1:0] axis_fault,
  output reg [1:0] operating,
  output reg [1:0] pos_control,
  output reg [1:0] error_flag,
  output reg [1:0] origin_decided,
  output reg [1:0] output_inhibit,
  output reg [1:0] speed_switch_pulse,
  output reg preset_done,
  output reg [15:0] preset_error_code,
  output reg irq
);
  localparam S_IDLE = 3'b001;
  localparam S_EXEC = 3'b010;
  localparam S_DONE = 3'b100;

  reg [2:0] state_q;
  reg [31:0] cmd_q;
  reg [31:0] preset_target_value;
  reg [31:0] axcfg_q;
  reg req_prev_q;
  reg axis_q;
  reg [2:0] code_q;
  reg cancel_q;
  reg [31:0] operand_q;
  reg [7:0] step_q [0:1];
  reg [31:0] pos_q [0:1];
  reg [31:0] enc_q [0:1];
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg [15:0] err_d;
  reg [1:0] ev_set;

  wire req_rise;
  wire hit_rd;
  wire hit_wr;
  wire [31:0] scaled_pos;

  // Requests start only from a low-to-high change of the request bit
  assign req_rise = cmd_q[`CMD_REQ_BIT] & ~req_prev_q;
  assign hit_rd = avs_read & avs_waitrequest;
  assign hit_wr = avs_write & ~avs_waitrequest;

  // Unit field picks a power-of-ten scale; keeps divide logic out
  assign scaled_pos = (axcfg_q[`CFG_UNIT_LSB +: 2] == 2'd1) ? {operand_q[28:0], 3'b000} +
    {operand_q[30:0], 1'b0} : operand_q;

  // Decision in the exec-to-done step; error flag wins over motion state
  always @* begin
    err_d = `ERR_NONE;
    if (code_q == `CODE_ECLR) begin
      err_d = `ERR_NONE;
    end else if (code_q < `CODE_PTV || code_q > `CODE_ECLR) begin
      err_d = `ERR_BAD_CMD;
    end else if (error_flag[axis_q] && code_q != `CODE_EPRE) begin
      err_d = `ERR_AXIS_FAULT;
    end else begin
      case (code_q)
        `CODE_PTV: begin
          if (operating[axis_q]) begin
            err_d = `ERR_PTV_RUN;
          end else if (!pos_control[axis_q]) begin
            err_d = `ERR_PTV_POS;
          end
        end
        `CODE_STEP: begin
          if (operating[axis_q]) begin
            err_d = `ERR_STEP_RUN;
          end else if (operand_q == 32'h0000_0000 || operand_q > {24'h0, `STEP_MAX}) begin
            err_d = `ERR_STEP_RANGE;
          end
        end
        `CODE_RSTEP: begin
          if (operand_q == 32'h0000_0000 || operand_q > {24'h0, `STEP_MAX}) begin
            err_d = `ERR_STEP_RANGE;
          end else if (!axcfg_q[axis_q]) begin
            err_d = `ERR_RSTEP_MODE;
          end
        end
        `CODE_PPRE: begin
          if (operating[axis_q]) begin
            err_d = `ERR_PPRE_RUN;
          end
        end
        default: begin
          err_d = `ERR_NONE;
        end
      endcase
    end
  end

  // Command sequencer
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      req_prev_q <= 1'b0;
      axis_q <= 1'b0;
      code_q <= 3'h0;
      cancel_q <= 1'b0;
      operand_q <= 32'h0000_0000;
      preset_done <= 1'b0;
      preset_error_code <= `ERR_NONE;
      origin_decided <= 2'b00;
      error_flag <= 2'b00;
      output_inhibit <= 2'b00;
      speed_switch_pulse <= 2'b00;
      step_q[0] <= `STEP_RESET;
      step_q[1] <= `STEP_RESET;
      pos_q[0] <= 32'h0000_0000;
      pos_q[1] <= 32'h0000_0000;
      enc_q[0] <= 32'h0000_0000;
      enc_q[1] <= 32'h0000_0000;
      ev_set <= 2'b00;
    end else begin
      req_prev_q <= cmd_q[`CMD_REQ_BIT];
      speed_switch_pulse <= 2'b00;
      ev_set <= 2'b00;
      // Faults from the motion core latch; only error clear removes them
      error_flag <= error_flag | axis_fault;
      output_inhibit <= output_inhibit | axis_fault;
      case (state_q)
        S_IDLE: begin
          if (req_rise) begin
            axis_q <= cmd_q[`CMD_AXIS_BIT];
            code_q <= cmd_q[`CMD_CODE_MSB:`CMD_CODE_LSB];
            cancel_q <= cmd_q[`CMD_CANCEL_BIT];
            operand_q <= preset_target_value;
            state_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          preset_error_code <= err_d;
          if (err_d == `ERR_NONE) begin
            preset_done <= 1'b1;
            ev_set <= 2'b01;
            case (code_q)
              `CODE_PTV: begin
                speed_switch_pulse[axis_q] <= 1'b1;
              end
              `CODE_STEP: begin
                step_q[axis_q] <= operand_q[7:0];
              end
              `CODE_RSTEP: begin
                step_q[axis_q] <= operand_q[7:0];
              end
              `CODE_PPRE: begin
                pos_q[axis_q] <= scaled_pos;
                origin_decided[axis_q] <= 1'b1;
              end
              `CODE_EPRE: begin
                enc_q[axis_q] <= operand_q;
              end
              `CODE_ECLR: begin
                error_flag[axis_q] <= axis_fault[axis_q];
                if (cancel_q) begin
                  output_inhibit[axis_q] <= axis_fault[axis_q];
                end
              end
              default: begin
              end
            endcase
          end else begin
            preset_done <= 1'b0;
            ev_set <= 2'b10;
          end
          state_q <= S_DONE;
        end
        S_DONE: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Status mirrors of the motion core
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      operating <= 2'b00;
    end else begin
      operating <= axis_running;
    end
  end

  // Unqualified by motion, so a switch can be asked for from standstill
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pos_control <= 2'b00;
    end else begin
      pos_control <= axis_pos_ctl;
    end
  end

  // Registered so the pin never glitches
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Avalon-MM slave: one wait cycle, then answer
  // A request sees waitrequest high again after each answer
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // Command word; software must write the request bit low, then high,
  // because only its rising edge starts a command
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_q <= 32'h0000_0000;
    end else if (hit_wr && avs_address == `OFS_CMD) begin
      cmd_q <= avs_writedata;
    end
  end

  // Operand for the next command; copied at the request edge,
  // so it may be rewritten while a command runs
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      preset_target_value <= 32'h0000_0000;
    end else if (hit_wr && avs_address == `OFS_OPERAND) begin
      preset_target_value <= avs_writedata;
    end
  end

  // Repeat bits and position unit
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      axcfg_q <= 32'h0000_0000;
    end else if (hit_wr && avs_address == `OFS_AXCFG) begin
      axcfg_q <= avs_writedata;
    end
  end

  // Interrupt enables
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_mask_q <= 2'b00;
    end else if (hit_wr && avs_address == `OFS_IRQ_MASK) begin
      irq_mask_q <= avs_writedata[1:0];
    end
  end

  // Sticky events; a new event in the clearing read survives it,
  // so no completion is ever lost to a poll
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_stat_q <= 2'b00;
    end else if (hit_rd && avs_address == `OFS_IRQ_STAT) begin
      irq_stat_q <= ev_set;
    end else begin
      irq_stat_q <= irq_stat_q | ev_set;
    end
  end

  wire [31:0] axstat_w [0:1];
  wire [31:0] result_w;
  reg [31:0] rd_word;
  genvar g;

  // One status word per axis
  generate
    for (g = 0; g < 2; g = g + 1) begin : axstat_gen
      assign axstat_w[g] = {27'h0, output_inhibit[g], origin_decided[g], error_flag[g],
        pos_control[g], operating[g]};
    end
  endgenerate

  // Done in bit 16, code below it
  assign result_w = {15'h0, preset_done, preset_error_code};

  // Unmapped words read as zero
  always @* begin
    rd_word = 32'h0000_0000;
    case (avs_address)
      `OFS_CMD: begin
        rd_word = cmd_q;
      end
      `OFS_OPERAND: begin
        rd_word = preset_target_value;
      end
      `OFS_RESULT: begin
        rd_word = result_w;
      end
      // Per-axis status, step, position and encoder words
      `OFS_AXSTAT_X: begin
        rd_word = axstat_w[0];
      end
      `OFS_AXSTAT_Y: begin
        rd_word = axstat_w[1];
      end
      `OFS_STEP_X: begin
        rd_word = {24'h0, step_q[0]};
      end
      `OFS_STEP_Y: begin
        rd_word = {24'h0, step_q[1]};
      end
      `OFS_POS_X: begin
        rd_word = pos_q[0];
      end
      `OFS_POS_Y: begin
        rd_word = pos_q[1];
      end
      `OFS_ENC_X: begin
        rd_word = enc_q[0];
      end
      `OFS_ENC_Y: begin
        rd_word = enc_q[1];
      end
      `OFS_AXCFG: begin
        rd_word = axcfg_q;
      end
      `OFS_IRQ_STAT: begin
        rd_word = {30'h0, irq_stat_q};
      end
      `OFS_IRQ_MASK: begin
        rd_word = {30'h0, irq_mask_q};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Read data stand until the next read
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (hit_rd) begin
      avs_readdata <= rd_word;
    end
  end
endmodule

// File: gatekeeper_props.sv
// Port-level assertions for the command gatekeeper
`timescale 1ns/1ns
module gatekeeper_props (
  input wire ref_clk,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [1:0] axis_running,
  input wire [1:0] axis_pos_ctl,
  input wire [1:0] axis_fault,
  input wire [1:0] operating,
  input wire [1:0] pos_control,
  input wire [1:0] error_flag,
  input wire [1:0] output_inhibit,
  input wire preset_done,
  input wire [15:0] preset_error_code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_oper; !$past(sys_rst) |-> operating == $past(axis_running); endproperty
  a_oper: assert property (p_oper) else $error("operating lag");
  property p_pos; !$past(sys_rst) |-> pos_control == $past(axis_pos_ctl); endproperty
  a_pos: assert property (p_pos) else $error("pos control");
  property p_flt; axis_fault[0] |=> error_flag[0]; endproperty
  a_flt: assert property (p_flt) else $error("error flag");
  property p_inh; axis_fault[1] |=> output_inhibit[1]; endproperty
  a_inh: assert property (p_inh) else $error("inhibit");
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait state");
  property p_low; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_low: assert property (p_low) else $error("wait low");
  property p_done; preset_done |-> preset_error_code == 16'h0000; endproperty
  a_done: assert property (p_done) else $error("done with code");
  property p_code; preset_error_code != 16'h0000 |-> preset_error_code inside
    {16'h137, 16'h13D, 16'h1B9, 16'h1BA, 16'h1BB, 16'h1C3, 16'h1, 16'h2}; endproperty
  a_code: assert property (p_code) else $error("bad code");
endmodule
bind axis_command_gatekeeper gatekeeper_props props_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .axis_running(axis_running), .axis_pos_ctl(axis_pos_ctl), .axis_fault(axis_fault),
  .operating(operating), .pos_control(pos_control), .error_flag(error_flag),
  .output_inhibit(output_inhibit), .preset_done(preset_done),
  .preset_error_code(preset_error_code));

// File: host_model.sv
// Host model: Avalon-MM master issuing gatekeeper commands
`timescale 1ns/1ns
module host_model (
  input wire ref_clk,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  output reg [3:0] avs_address,
  output reg avs_read,
  output reg avs_write,
  output reg [31:0] avs_writedata,
  output reg hung
);
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata, hung} = 39'h0;
  end
  // Request held until waitrequest is sampled low, then released
  task xfer(input w, input [3:0] a, input [31:0] wd, output [31:0] rd);
    integer n;
    begin
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= wd;
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (avs_waitrequest && n < 50);
      if (n == 50) hung <= 1'h1;
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
    end
  endtask
  // k is {cancel, axis, code}; request bit dropped first so it rises again
  task cmd(input [4:0] k, input [31:0] op);
    reg [31:0] d;
    begin
      xfer(1'h1, 4'h1, op, d);
      xfer(1'h1, 4'h0, {25'h0, k[2:0], 1'h0, k[4], k[3], 1'h0}, d);
      xfer(1'h1, 4'h0, {25'h0, k[2:0], 1'h0, k[4], k[3], 1'h1}, d);
    end
  endtask
endmodule

// File: axis_command_gatekeeper_tb_top.sv
// Self-checking bench for the command gatekeeper
`timescale 1ns/1ns
module axis_command_gatekeeper_tb_top;
  reg ref_clk = 0;
  reg sys_rst = 1;
  reg [1:0] axis_running = 0;
  reg [1:0] axis_pos_ctl = 0;
  reg [1:0] axis_fault = 0;
  wire [3:0] avs_address;
  wire avs_read, avs_write, avs_waitrequest, preset_done, irq, hung;
  wire [31:0] avs_writedata, avs_readdata;
  wire [1:0] operating, pos_control, error_flag, origin_decided, output_inhibit;
  wire [1:0] speed_switch_pulse;
  wire [15:0] preset_error_code;
  integer failures = 0;
  integer checks_done = 0;
  reg [31:0] d;
  reg [1:0] sw_seen = 2'b00;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) sw_seen <= sw_seen | speed_switch_pulse;
  host_model host_u (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .hung(hung));
  axis_command_gatekeeper dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .axis_running(axis_running),
    .axis_pos_ctl(axis_pos_ctl), .axis_fault(axis_fault), .operating(operating),
    .pos_control(pos_control), .error_flag(error_flag), .origin_decided(origin_decided),
    .output_inhibit(output_inhibit), .speed_switch_pulse(speed_switch_pulse),
    .preset_done(preset_done), .preset_error_code(preset_error_code), .irq(irq));
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rchk(input [3:0] a, input [31:0] e);
    begin
      host_u.xfer(1'h0, a, 32'h0, d);
      chk("rdata", e, d);
    end
  endtask
  // Result is known two edges after the request write; four covers it
  task run(input [4:0] k, input [31:0] op, input [15:0] e);
    begin
      host_u.cmd(k, op);
      repeat (4) @(posedge ref_clk);
      rchk(4'h2, {15'h0, e == 16'h0, e});
    end
  endtask
  task motion(input [1:0] r, input [1:0] p, input [1:0] f);
    begin
      @(posedge ref_clk);
      axis_running <= r;
      axis_pos_ctl <= p;
      axis_fault <= f;
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task t_step;
    begin
      rchk(4'h5, 32'h1);
      rchk(4'hE, 32'h0);
      run(5'h02, 32'h96, 16'h0);
      rchk(4'h5, 32'h96);
      run(5'h0A, 32'h32, 16'h0);
      rchk(4'h6, 32'h32);
      run(5'h02, 32'h97, 16'h1BA);
      run(5'h02, 32'h0, 16'h1BA);
      motion(2'h1, 2'h0, 2'h0);
      run(5'h02, 32'h5, 16'h1B9);
      rchk(4'h5, 32'h96);
    end
  endtask
  task t_ptv;
    begin
      motion(2'h0, 2'h0, 2'h0);
      run(5'h01, 32'h0, 16'h13D);
      chk("switch", 32'h0, {30'h0, sw_seen});
      motion(2'h0, 2'h1, 2'h0);
      run(5'h01, 32'h0, 16'h0);
      chk("switch", 32'h1, {30'h0, sw_seen});
      motion(2'h1, 2'h1, 2'h0);
      chk("posctl", 32'h1, {30'h0, pos_control});
      chk("oper", 32'h1, {30'h0, operating});
      run(5'h09, 32'h0, 16'h13D);
      run(5'h01, 32'h0, 16'h137);
      chk("switch", 32'h1, {30'h0, sw_seen});
      run(5'h04, 32'h1, 16'h1C3);
      motion(2'h0, 2'h0, 2'h0);
    end
  endtask
  task t_cfg;
    begin
      run(5'h03, 32'hB, 16'h1BB);
      host_u.xfer(1'h1, 4'hB, 32'h1, d);
      run(5'h03, 32'hB, 16'h0);
      rchk(4'h5, 32'hB);
      run(5'h04, 32'h1388, 16'h0);
      rchk(4'h7, 32'h1388);
      chk("origin", 32'h1, {30'h0, origin_decided});
      host_u.xfer(1'h1, 4'hB, 32'h11, d);
      run(5'h0C, 32'h7, 16'h0);
      rchk(4'h8, 32'h46);
    end
  endtask
  task t_irq;
    begin
      host_u.xfer(1'h0, 4'hC, 32'h0, d);
      host_u.xfer(1'h1, 4'hD, 32'h1, d);
      run(5'h0D, 32'h7D0, 16'h0);
      rchk(4'hA, 32'h7D0);
      chk("irq", 32'h1, {31'h0, irq});
      rchk(4'hC, 32'h1);
      run(5'h07, 32'h0, 16'h2);
      chk("irq", 32'h0, {31'h0, irq});
    end
  endtask
  task t_fault;
    begin
      motion(2'h1, 2'h0, 2'h1);
      chk("errflag", 32'h1, {30'h0, error_flag});
      run(5'h02, 32'h3, 16'h1);
      motion(2'h0, 2'h0, 2'h0);
      run(5'h16, 32'h0, 16'h0);
      chk("cleared", 32'h0, {28'h0, error_flag, output_inhibit});
    end
  endtask
  task end_of_test;
    begin
      if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge hung) begin
    failures = failures + 1;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_step;
    t_ptv;
    t_cfg;
    t_irq;
    t_fault;
    end_of_test;
  end
endmodule
